// *** logic/gpos_device.sv ***
/*
 * Transceiver end: per-pin signal selection, polarity, divided clock
 * output and the synchronous / asynchronous serial data paths.
 * Assumes status inputs come from logic on core_clk; only pin levels
 * come from outside and are synchronised.
 */
`timescale 1ns/100ps
module gpos_device
    import gpos_pkg::*;
#(
    parameter int PQ_W     = 3,
    parameter int BIT_CYCS = BIT_CYC,
    parameter int SYM_HALF = BIT_CYC / 2
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    gpos_if.device                pins,
    input  wire logic [2:0][5:0]  pinSignalSelect,
    input  wire logic [2:0]       pinPolarityInvert,
    input  wire logic [1:0]       frameFormatField,
    input  wire logic [1:0]       clearChannelSetting,
    input  wire logic [PQ_W-1:0]  preambleQualityValue,
    input  wire logic [PQ_W-1:0]  preambleQualityThreshold,
    input  wire logic [4:0]       radioStateCode,
    input  wire logic             rxFifoAtThr,
    input  wire logic             rxFifoEmpty,
    input  wire logic             rxEndOfPacket,
    input  wire logic             txFifoAtThr,
    input  wire logic             txFifoFull,
    input  wire logic             rxOverflowEvt,
    input  wire logic             txUnderflowEvt,
    input  wire logic             rxFlush,
    input  wire logic             txFlush,
    input  wire logic             syncWordEvt,
    input  wire logic             packetEnd,
    input  wire logic             packetDiscard,
    input  wire logic             crcOkEvt,
    input  wire logic             rxFirstByteRead,
    input  wire logic             rssiBelowThr,
    input  wire logic             rxPacketBusy,
    input  wire logic             rssiAboveThr,
    input  wire logic             enterIdle,
    input  wire logic             crcCheckDone,
    input  wire logic             crcMatch,
    input  wire logic             lockDetect,
    input  wire logic [1:0]       hardData,
    input  wire logic             symbolStart,
    input  wire logic             txActive,
    input  wire logic             rxActive,
    input  wire logic             rxBit,
    input  wire logic             rxBitValid,
    output logic                  rxBitReady,
    output logic                  txAirBit,
    output logic                  txAirValid,
    output logic                  packetBypass,
    output logic                  mskAllowed,
    output logic                  addrFilterAllowed
);
    localparam int OVS_CYCS = BIT_CYCS / OVS_FACTOR;
    localparam int BCW      = $clog2(BIT_CYCS + 1);
    localparam int SCW      = $clog2(SYM_HALF + 1);

    typedef struct packed {
        logic                   rxEop;
        logic                   txFull;
        logic                   rxOvf;
        logic                   txUnf;
        logic                   syncOn;
        logic                   crcPkt;
        logic                   pqOn;
        logic                   pqAbove;
        logic                   cs;
        logic                   crcLast;
        logic                   inRx;
        logic [SCW-1:0]         symCnt;
        logic                   symTick;
        gpos_period_t           divCnt;
        logic                   clkOut;
        logic [BCW-1:0]         bitCnt;
        logic                   serClk;
        logic [BCW-1:0]         ovsCnt;
        logic                   pinSync1;
        logic                   pinSync2;
        logic [TX_LAT_BITS-1:0] txDelay;
        logic                   txAir;
        logic                   txAirVld;
        logic [RX_LAT_BITS-1:0] rxDelay;
        logic [1:0]             bufData;
        logic [1:0]             bufCnt;
        logic                   rawBit;
        logic [2:0]             pinOut;
        logic [2:0]             pinOe;
    } gpos_dev_state_t;

    gpos_dev_state_t state_r;
    gpos_dev_state_t state_nxt;

    logic       syncMode;
    logic       asyncMode;
    logic       pin0Input;
    logic       riseEn;
    logic       fallEn;
    logic       ovsEn;
    logic       push;
    logic       pop;
    logic       popBit;
    logic       pqNow;
    logic       ccaOut;
    logic       clkSel;
    logic [1:0] clkPin;
    logic [2:0] hasClk;
    logic       sigBit;

    assign syncMode  = (frameFormatField == FMT_SYNC);
    assign asyncMode = (frameFormatField == FMT_ASYNC);
    assign pin0Input = asyncMode | (syncMode & txActive);
    assign riseEn    = (state_r.bitCnt == '0);
    assign fallEn    = (state_r.bitCnt == BCW'(BIT_CYCS / 2));
    assign ovsEn     = (state_r.ovsCnt == '0);
    assign pqNow     = (preambleQualityValue > preambleQualityThreshold);
    assign packetBypass      = asyncMode;
    assign mskAllowed        = ~asyncMode;
    assign addrFilterAllowed = ~syncMode;
    // two-entry buffer: a slow bit clock only stalls the radio side
    assign rxBitReady = asyncMode | (state_r.bufCnt != 2'h2);
    assign push   = rxBitValid & rxBitReady & ~asyncMode;
    assign pop    = fallEn & syncMode & rxActive & (state_r.bufCnt != '0);
    assign popBit = state_r.bufData[0];
    assign txAirBit   = state_r.txAir;
    assign txAirValid = state_r.txAirVld;

    // clear-channel qualification by mode
    always_comb begin
        unique case (clearChannelSetting)
            2'h0: ccaOut = 1'b1;
            2'h1: ccaOut = rssiBelowThr;
            2'h2: ccaOut = ~rxPacketBusy;
            2'h3: ccaOut = rssiBelowThr & ~rxPacketBusy;
        endcase
    end

    // lowest pin asking for a divided clock owns the divider
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            hasClk[i] = (pinSignalSelect[i] >= SEL_CLK_BASE);
        end
        clkSel = |hasClk;
        clkPin = hasClk[0] ? 2'h0 : (hasClk[1] ? 2'h1 : 2'h2);
    end

    always_comb begin
        state_nxt = state_r;
        sigBit    = 1'b0;
        // status flags; the set term wins over the clear term, except cs, where enterIdle masks rssiAboveThr
        state_nxt.rxEop = (rxFifoAtThr | rxEndOfPacket)
                        | (state_r.rxEop & ~rxFifoEmpty);
        state_nxt.txFull = txFifoFull
                         | (state_r.txFull & txFifoAtThr);
        state_nxt.rxOvf = rxOverflowEvt | (state_r.rxOvf & ~rxFlush);
        state_nxt.txUnf = txUnderflowEvt | (state_r.txUnf & ~txFlush);
        state_nxt.syncOn = syncWordEvt | (state_r.syncOn & ~(packetEnd
                         | packetDiscard | rxOverflowEvt
                         | txUnderflowEvt));
        state_nxt.crcPkt = crcOkEvt
                         | (state_r.crcPkt & ~rxFirstByteRead);
        state_nxt.inRx    = (radioStateCode == RADIO_RX);
        state_nxt.pqAbove = pqNow;
        // quality flag rises on crossing, drops below it or on rx re-entry
        state_nxt.pqOn = (pqNow & ~state_r.pqAbove)
                       | (state_r.pqOn & pqNow
                       & ~(state_nxt.inRx & ~state_r.inRx));
        state_nxt.cs = rssiAboveThr & ~enterIdle;
        if (crcCheckDone) begin
            state_nxt.crcLast = crcMatch;
        end else if (state_nxt.inRx & ~state_r.inRx) begin
            state_nxt.crcLast = 1'b0;
        end
        // half-symbol strobe
        if (symbolStart) begin
            state_nxt.symTick = 1'b1;
            state_nxt.symCnt  = SCW'(SYM_HALF - 1);
        end else if (state_r.symCnt != '0) begin
            state_nxt.symCnt = state_r.symCnt - 1'b1;
        end else begin
            state_nxt.symTick = 1'b0;
        end
        // divided crystal clock; high for the rounded-up half period
        if (!clkSel || state_r.divCnt >= gpos_clk_period(
                pinSignalSelect[clkPin][3:0]) - 1'b1) begin
            state_nxt.divCnt = '0;
        end else begin
            state_nxt.divCnt = state_r.divCnt + 1'b1;
        end
        // spare bit so the doubled count of the slowest divider fits
        state_nxt.clkOut = clkSel & ({state_nxt.divCnt, 1'b0} <
            {1'b0, gpos_clk_period(pinSignalSelect[clkPin][3:0])});
        // bit clock and eight-times oversampling dividers
        state_nxt.bitCnt = (state_r.bitCnt == BCW'(BIT_CYCS - 1))
                         ? '0 : state_r.bitCnt + 1'b1;
        state_nxt.ovsCnt = (state_r.ovsCnt == BCW'(OVS_CYCS - 1))
                         ? '0 : state_r.ovsCnt + 1'b1;
        if (riseEn) begin
            state_nxt.serClk = 1'b1;
        end else if (fallEn) begin
            state_nxt.serClk = 1'b0;
        end
        // pin zero level from the host, first stage feeds only the second
        state_nxt.pinSync1 = pins.level[0];
        state_nxt.pinSync2 = state_r.pinSync1;
        state_nxt.txAirVld = 1'b0;
        if (asyncMode && ovsEn) begin
            state_nxt.txAir    = state_r.pinSync2;
            state_nxt.txAirVld = txActive;
            state_nxt.rawBit   = rxBit;
        end else if (syncMode && txActive && riseEn) begin
            state_nxt.txDelay = {state_r.txDelay[TX_LAT_BITS-2:0],
                                 state_r.pinSync2};
            state_nxt.txAir    = state_r.txDelay[TX_LAT_BITS-1];
            state_nxt.txAirVld = 1'b1;
        end
        // rx bits leave the buffer on the falling edge into the delay line
        if (pop) begin
            state_nxt.rxDelay = {state_r.rxDelay[RX_LAT_BITS-2:0],
                                 popBit};
        end
        unique case ({push, pop})
            2'b10: begin
                state_nxt.bufData[state_r.bufCnt[0]] = rxBit;
                state_nxt.bufCnt = state_r.bufCnt + 1'b1;
            end
            2'b01: begin
                state_nxt.bufData = {1'b0, state_r.bufData[1]};
                state_nxt.bufCnt  = state_r.bufCnt - 1'b1;
            end
            2'b11: begin
                state_nxt.bufData = state_r.bufCnt[1]
                                  ? {rxBit, state_r.bufData[1]}
                                  : {1'b0, rxBit};
            end
            2'b00: begin
                state_nxt.bufData = state_r.bufData;
            end
        endcase
        // per-pin select, then polarity; reserved codes give low
        for (int i = 0; i < 3; i++) begin
            unique case (pinSignalSelect[i])
                SEL_RX_THR:     sigBit = rxFifoAtThr;
                SEL_RX_THR_EOP: sigBit = state_r.rxEop;
                SEL_TX_THR:     sigBit = txFifoAtThr;
                SEL_TX_FULL:    sigBit = state_r.txFull;
                SEL_RX_OVF:     sigBit = state_r.rxOvf;
                SEL_TX_UNF:     sigBit = state_r.txUnf;
                SEL_SYNC:       sigBit = state_r.syncOn;
                SEL_CRC_PKT:    sigBit = state_r.crcPkt;
                SEL_PQT:        sigBit = state_r.pqOn;
                SEL_CCA:        sigBit = ccaOut;
                SEL_LOCK:       sigBit = lockDetect;
                SEL_SER_CLK:    sigBit = state_r.serClk;
                SEL_SYNC_DATA:  sigBit = state_r.rxDelay[RX_LAT_BITS-1];
                SEL_ASYNC_DATA: sigBit = state_r.rawBit;
                SEL_CS:         sigBit = state_r.cs;
                SEL_CRC_LAST:   sigBit = state_r.crcLast;
                SEL_HARD1:      sigBit = hardData[1];
                SEL_HARD0:      sigBit = hardData[0];
                SEL_SYM_TICK:   sigBit = state_r.symTick;
                SEL_PIN0_EN_N:  sigBit = ~pin0Input;
                SEL_LOW:        sigBit = 1'b0;
                default: begin
                    sigBit = hasClk[i] && (clkPin == 2'(i))
                           && state_r.clkOut;
                end
            endcase
            state_nxt.pinOut[i] = sigBit ^ pinPolarityInvert[i];
            state_nxt.pinOe[i]  = (pinSignalSelect[i] != SEL_HIZ)
                                & ~((i == 0) & pin0Input);
        end
    end

    assign pins.devOut = state_r.pinOut;
    assign pins.devOe  = state_r.pinOe;

    // state register; the pins stay undriven during reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end
endmodule : gpos_device

// *** logic/gpos_pkg.sv ***
/*
 * Shared constants for the general-purpose output select and serial
 * data blocks: select codes, frame formats, latencies, clock rate.
 * Assumes both ends run from core_clk at the rate named here.
 */
package gpos_pkg;
    localparam logic [5:0] SEL_RX_THR     = 6'h00;
    localparam logic [5:0] SEL_RX_THR_EOP = 6'h01;
    localparam logic [5:0] SEL_TX_THR     = 6'h02;
    localparam logic [5:0] SEL_TX_FULL    = 6'h03;
    localparam logic [5:0] SEL_RX_OVF     = 6'h04;
    localparam logic [5:0] SEL_TX_UNF     = 6'h05;
    localparam logic [5:0] SEL_SYNC       = 6'h06;
    localparam logic [5:0] SEL_CRC_PKT    = 6'h07;
    localparam logic [5:0] SEL_PQT        = 6'h08;
    localparam logic [5:0] SEL_CCA        = 6'h09;
    localparam logic [5:0] SEL_LOCK       = 6'h0A;
    localparam logic [5:0] SEL_SER_CLK    = 6'h0B;
    localparam logic [5:0] SEL_SYNC_DATA  = 6'h0C;
    localparam logic [5:0] SEL_ASYNC_DATA = 6'h0D;
    localparam logic [5:0] SEL_CS         = 6'h0E;
    localparam logic [5:0] SEL_CRC_LAST   = 6'h0F;
    localparam logic [5:0] SEL_HARD1      = 6'h16;
    localparam logic [5:0] SEL_HARD0      = 6'h17;
    localparam logic [5:0] SEL_SYM_TICK   = 6'h1D;
    localparam logic [5:0] SEL_PIN0_EN_N  = 6'h2D;
    localparam logic [5:0] SEL_HIZ        = 6'h2E;
    localparam logic [5:0] SEL_LOW        = 6'h2F;
    localparam logic [5:0] SEL_CLK_BASE   = 6'h30;

    localparam logic [1:0] FMT_SYNC  = 2'h1;
    localparam logic [1:0] FMT_ASYNC = 2'h3;
    localparam logic [4:0] RADIO_RX  = 5'h0D;

    localparam int OVS_FACTOR   = 8;
    localparam int TX_LAT_BITS  = 8;
    localparam int RX_LAT_BITS  = 9;
    localparam int CLK_HZ       = 25_000_000;
    localparam int DATA_RATE_HZ = 312_500;
    localparam int BIT_CYC      = CLK_HZ / DATA_RATE_HZ;

    typedef logic [8:0] gpos_period_t;

    // divided clock period in core cycles, one crystal cycle = 2 cycles
    function automatic gpos_period_t gpos_clk_period(
        input logic [3:0] idx
    );
        unique case (idx)
            4'h0: gpos_clk_period = 9'h002;
            4'h1: gpos_clk_period = 9'h003;
            4'h2: gpos_clk_period = 9'h004;
            4'h3: gpos_clk_period = 9'h006;
            4'h4: gpos_clk_period = 9'h008;
            4'h5: gpos_clk_period = 9'h00C;
            4'h6: gpos_clk_period = 9'h010;
            4'h7: gpos_clk_period = 9'h018;
            4'h8: gpos_clk_period = 9'h020;
            4'h9: gpos_clk_period = 9'h030;
            4'hA: gpos_clk_period = 9'h040;
            4'hB: gpos_clk_period = 9'h060;
            4'hC: gpos_clk_period = 9'h080;
            4'hD: gpos_clk_period = 9'h0C0;
            4'hE: gpos_clk_period = 9'h100;
            4'hF: gpos_clk_period = 9'h180;
        endcase
    endfunction : gpos_clk_period
endpackage : gpos_pkg

// *** logic/gpos_if.sv ***
/*
 * The three general-purpose pins between transceiver and host.
 * Assumes each end drives a pin only with its enable high; an
 * undriven pin resolves low here.
 */
`timescale 1ns/100ps
interface gpos_if;
    logic [2:0] devOut;
    logic [2:0] devOe;
    logic [2:0] hostOut;
    logic [2:0] hostOe;
    logic [2:0] level;

    // wire resolution, device wins a clash
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            level[i] = devOe[i] ? devOut[i] : (hostOe[i] & hostOut[i]);
        end
    end

    modport device (output devOut, output devOe, input level);
    modport host (output hostOut, output hostOe, input level);
endinterface : gpos_if

// *** logic/gpos_host.sv ***
/*
 * Host end: samples the pins, recovers synchronous receive bits on
 * the bit clock, presents transmit bits after its falling edge, and
 * paces asynchronous transmit from its own divider.
 * Assumes the user side is on core_clk; pins are synchronised.
 */
`timescale 1ns/100ps
module gpos_host
    import gpos_pkg::*;
#(
    parameter int ASYNC_CYCS = BIT_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    gpos_if.host             pins,
    input  wire logic [1:0]  clkPinSel,
    input  wire logic [1:0]  dataPinSel,
    input  wire logic        syncMode,
    input  wire logic        asyncMode,
    input  wire logic        txEnable,
    input  wire logic        txBit,
    input  wire logic        txValid,
    output logic             txReady,
    output logic             rxBit,
    output logic             rxValid,
    output logic             rawLevel
);
    localparam int ACW = $clog2(ASYNC_CYCS + 1);

    typedef struct packed {
        logic [2:0]     sync1;
        logic [2:0]     sync2;
        logic           clkD;
        logic           drv;
        logic           drvOe;
        logic [ACW-1:0] aCnt;
        logic           rxB;
        logic           rxV;
        logic           raw;
    } gpos_host_state_t;

    gpos_host_state_t state_r;
    gpos_host_state_t state_nxt;

    logic clkNow;
    logic fallDet;
    logic riseDet;
    logic aTick;

    assign clkNow  = state_r.sync2[clkPinSel];
    assign fallDet = state_r.clkD & ~clkNow;
    assign riseDet = ~state_r.clkD & clkNow;
    assign aTick   = (state_r.aCnt == '0);
    // framing bits, when the device leaves them out, ride in this stream
    assign txReady = txEnable & ((syncMode & fallDet)
                   | (asyncMode & aTick));
    assign rxBit    = state_r.rxB;
    assign rxValid  = state_r.rxV;
    assign rawLevel = state_r.raw;
    assign pins.hostOut = {2'b00, state_r.drv};
    assign pins.hostOe  = {2'b00, state_r.drvOe};

    always_comb begin
        state_nxt       = state_r;
        state_nxt.sync1 = pins.level;
        state_nxt.sync2 = state_r.sync1;
        state_nxt.clkD  = clkNow;
        state_nxt.rxV   = 1'b0;
        // own bit-period divider keeps async error well under 1/8 bit
        state_nxt.aCnt = (!asyncMode || state_r.aCnt == ACW'(ASYNC_CYCS - 1))
                       ? '0 : state_r.aCnt + 1'b1;
        state_nxt.drvOe = txEnable & (syncMode | asyncMode);
        if (txReady && txValid) begin
            state_nxt.drv = txBit;           // changes after fall, or on the async divider tick
        end
        // sync rx sampled on rise, half a bit after the device update
        if (syncMode && riseDet) begin
            state_nxt.rxB = state_r.sync2[dataPinSel];
            state_nxt.rxV = 1'b1;
        end
        // every core cycle oversamples the raw async line
        state_nxt.raw = state_r.sync2[dataPinSel];
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end
endmodule : gpos_host

// *** bench/gpos_sva.sv ***
/*
 * Pin-level checks on the interface joining device and host ends.
 * Assumes the bench instantiates it beside that interface.
 */
`timescale 1ns/100ps
module gpos_sva (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic [2:0] devOut,
    input wire logic [2:0] devOe,
    input wire logic [2:0] hostOut,
    input wire logic [2:0] hostOe,
    input wire logic [2:0] level
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // reset itself disables, so the state is judged on release
    a_release_quiet: assert property (
        $fell(rst) |-> devOe == 3'h0 && hostOe == 3'h0)
        else $error("pin enables not clear after reset");
    a_release_low: assert property (
        $fell(rst) |-> devOut == 3'h0)
        else $error("pin data not clear after reset");
    a_host_pin_only: assert property (hostOe[2:1] == 2'h0)
        else $error("host drives a pin other than pin zero");
    a_pin0_turn: assert property (hostOe[0] |-> !devOe[0])
        else $error("device drives pin zero while host drives it");
    a_dev_wins: assert property (
        (level & devOe) == (devOut & devOe))
        else $error("driven pin level differs from device data");
    a_float_low: assert property (
        (level & ~(devOe | hostOe)) == 3'h0)
        else $error("undriven pin not low");
    a_host_level: assert property (
        hostOe[0] && !devOe[0] |-> level[0] == hostOut[0])
        else $error("pin zero level differs from host data");
    // host bits are paced by its divider or the bit clock, never faster
    a_tx_bit_hold: assert property (
        $changed(hostOut[0]) |=> $stable(hostOut[0])[*7])
        else $error("host transmit bit changed too soon");

    c_pin0_turn: cover property (hostOe[0]);
    c_pin1_high: cover property (level[1]);
    c_tx_change: cover property ($changed(hostOut[0]));
endmodule : gpos_sva

// *** bench/gpos_tb.sv ***
/*
 * Self-checking bench: device and host ends joined over the pins.
 * Assumes shortened bit periods; status inputs are shared levels and pulses.
 */
`timescale 1ns/100ps
module gpos_tb
    import gpos_pkg::*;
;
    logic core_clk = 1'b0, rst = 1'b1, lvl = 1'b0, seen1;
    logic [3:0] setP = 4'h0, clrP = 4'h0;
    logic [2:0][5:0] pinSignalSelect = {3{6'h2E}};
    logic [2:0] pinPolarityInvert = 3'h0;
    logic [2:0] preambleQualityValue = 3'h0;
    logic [2:0] preambleQualityThreshold = 3'h3;
    logic [1:0] frameFormatField = 2'h0, clearChannelSetting = 2'h1;
    logic [1:0] clkPinSel = 2'h1, dataPinSel = 2'h2;
    logic [4:0] radioStateCode = 5'h01;
    logic txActive = 1'b0, rxBit = 1'b0, asyncMode = 1'b0;
    logic txEnable = 1'b0, txBit = 1'b0, txValid = 1'b0;
    logic rxBitReady, txAirBit, txAirValid, packetBypass, mskAllowed;
    logic addrFilterAllowed, txReady, hostRx, rxValid, rawLevel;
    int fails = 0, tests_run = 0;
    int nRx = 0, nTx = 0, nAir = 0;
    // one shared level feeds all level inputs; pulses feed events
    wire rxFifoAtThr = lvl, txFifoAtThr = lvl, txFifoFull = lvl;
    wire rssiBelowThr = lvl, rssiAboveThr = lvl, lockDetect = lvl;
    wire crcMatch = lvl, rxPacketBusy = lvl, rxActive = lvl;
    wire rxBitValid = lvl, rxFifoEmpty = !lvl;
    wire [1:0] hardData = {lvl, !lvl};
    wire syncMode = frameFormatField == FMT_SYNC;
    wire rxOverflowEvt = setP[0], rxEndOfPacket = setP[0];
    wire txUnderflowEvt = setP[1], symbolStart = setP[1];
    wire syncWordEvt = setP[2], crcOkEvt = setP[3], crcCheckDone = setP[3];
    wire rxFlush = clrP[0], txFlush = clrP[1], enterIdle = clrP[1];
    wire packetEnd = clrP[2], packetDiscard = clrP[2];
    wire rxFirstByteRead = clrP[3];
    // rows: select, invert, level, expected pin level
    logic [8:0] rows [14] = '{9'h003, 9'h000, 9'h016, 9'h04B, 9'h050,
        9'h073, 9'h0B3, 9'h0BA, 9'h176, 9'h178, 9'h17D, 9'h085,
        9'h01B, 9'h018};

    gpos_if bus ();
    gpos_device #(.BIT_CYCS(16), .SYM_HALF(8)) i_gpos_device (.pins(bus), .*);
    gpos_host #(.ASYNC_CYCS(16)) i_gpos_host (.pins(bus), .rxBit(hostRx), .*);
    gpos_sva i_gpos_sva (.core_clk(core_clk), .rst(rst),
        .devOut(bus.devOut), .devOe(bus.devOe), .hostOut(bus.hostOut),
        .hostOe(bus.hostOe), .level(bus.level));

    always #20 core_clk = ~core_clk;

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc
    // look away from the rising edge so registered pins have settled
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask : wt
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic pulse(input logic [3:0] s, input logic [3:0] c);
        cyc(1);
        setP <= s;
        clrP <= c;
        cyc(1);
        setP <= 4'h0;
        clrP <= 4'h0;
    endtask : pulse
    task final_report;
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report

    // hang guard, far beyond the whole sequence
    initial begin
        #1000000;
        fails++;
        final_report();
    end

    initial begin
        cyc(20);
        rst <= 1'b0;
        wt(1);
        // pins idle, buffer ready, no strobes straight after reset
        chk(8'({rxBitReady, txAirValid, rxValid, bus.level}),
            8'h20);
        foreach (rows[i]) begin
            cyc(1);
            pinSignalSelect[1] <= rows[i][8:3];
            pinPolarityInvert[1] <= rows[i][2];
            lvl <= rows[i][1];
            wt(3);
            chk(8'(bus.level[1]),
                8'(rows[i][0]));
        end
        // sticky flags: set wins over a clear in the same cycle
        for (int k = 0; k < 4; k++) begin
            cyc(1);
            pinSignalSelect[1] <= SEL_RX_OVF + 6'(k);
            pulse(4'h1 << k, 4'h0);
            wt(3);
            chk(8'(bus.level[1]), 8'h01);
            pulse(4'h1 << k, 4'h1 << k);
            wt(3);
            chk(8'(bus.level[1]), 8'h01);
            pulse(4'h0, 4'h1 << k);
            wt(3);
            chk(8'(bus.level[1]), 8'h00);
        end
        cyc(1);
        pinSignalSelect[1] <= SEL_PQT;
        preambleQualityValue <= 3'h5;
        wt(3);
        chk(8'(bus.level[1]), 8'h01);
        cyc(1);
        radioStateCode <= RADIO_RX;
        wt(3);
        chk(8'(bus.level[1]), 8'h00);
        // second divided clock is refused, first toggles each cycle
        cyc(1);
        pinSignalSelect[1] <= SEL_CLK_BASE;
        pinSignalSelect[2] <= SEL_CLK_BASE + 6'h01;
        wt(4);
        chk(8'(bus.level[2]), 8'h00);
        seen1 = bus.level[1];
        wt(1);
        chk(8'(bus.level[1]), 8'(!seen1));
        cyc(1);
        pinSignalSelect[1] <= SEL_PIN0_EN_N;
        pinSignalSelect[2] <= SEL_ASYNC_DATA;
        frameFormatField <= FMT_ASYNC;
        asyncMode <= 1'b1;
        txActive <= 1'b1;
        rxBit <= 1'b1;
        txBit <= 1'b1;
        txValid <= 1'b1;
        wt(3);
        chk(8'(bus.level[1]), 8'h00);
        chk(8'({packetBypass, mskAllowed}), 8'h02);
        cyc(1);
        txEnable <= 1'b1;
        wt(60);
        chk(8'({txAirBit, rawLevel}), 8'h03);
        cyc(1);
        txBit <= 1'b0;
        rxBit <= 1'b0;
        wt(60);
        chk(8'({txAirBit, rawLevel}), 8'h00);
        cyc(1);
        txEnable <= 1'b0;
        cyc(2);
        frameFormatField <= FMT_SYNC;
        asyncMode <= 1'b0;
        txActive <= 1'b0;
        wt(3);
        chk(8'({addrFilterAllowed, bus.level[1]}), 8'h01);
        cyc(1);
        txActive <= 1'b1;
        wt(3);
        chk(8'(bus.level[1]), 8'h00);
        // sync link both ways: bit clock on pin one, rx data on pin two
        cyc(1);
        pinSignalSelect[1] <= SEL_SER_CLK;
        pinSignalSelect[2] <= SEL_SYNC_DATA;
        lvl <= 1'b1;
        rxBit <= 1'b1;
        txBit <= 1'b1;
        txEnable <= 1'b1;
        // settle first: the select switch may fake one clock edge
        wt(20);
        // ten bit periods hold exactly one strobe of each kind per bit
        repeat (10 * 16) begin
            @(negedge core_clk);
            nRx += int'(rxValid);
            nTx += int'(txReady);
            nAir += int'(txAirValid);
        end
        chk(8'(nRx), 8'h0A);
        chk(8'(nTx), 8'h0A);
        chk(8'(nAir), 8'h0A);
        wt(60);
        chk(8'({txAirBit, hostRx}), 8'h03);
        final_report();
    end
endmodule : gpos_tb
